// File: rtl/updown_pkg.sv
package updown_pkg;

   // Count geometry
   localparam int CNT_W = 4;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_MAX = 4'hF;
   localparam logic [3:0] CNT_ONE = 4'h1;

   // Bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // Register byte offsets
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STEP_OFS = 12'h004;
   localparam logic [11:0] STATUS_OFS = 12'h008;
   localparam logic [11:0] PRESET_OFS = 12'h00C;

   // Control register fields
   localparam int CTRL_CLEAR_BIT = 0;
   localparam int CTRL_LOAD_BIT = 1;
   localparam int CTRL_SRC_BIT = 2;
   localparam logic [2:0] CTRL_RST = 3'h0;

   // Step register fields, write-only pulses
   localparam int STEP_UP_BIT = 0;
   localparam int STEP_DOWN_BIT = 1;

   // Status register fields
   localparam int STAT_CNT_LSB = 0;
   localparam int STAT_CARRY_BIT = 4;
   localparam int STAT_BORROW_BIT = 5;
   localparam int STAT_UP_BIT = 6;
   localparam int STAT_DOWN_BIT = 7;

   // Preset register reset value
   localparam logic [3:0] PRESET_RST = 4'h0;

   // Idle level of the count inputs and their history flops
   localparam logic IDLE_HIGH = 1'b1;

   // Bus answer phases
   typedef enum logic [0:0] {
      BUS_WAIT = 1'b0,
      BUS_DONE = 1'b1
   } bus_phase_e;

endpackage

// File: rtl/rise_detect.sv
`timescale 1ns/10ps
module rise_detect
   import updown_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Sampled level and its rising edge
   input wire logic level_in,
   output logic rise_out
);

   // Previous level, idles high so no edge is seen after reset
   logic prev_ff;
   logic nxt_prev;

   // Next history value
   always_comb begin
      nxt_prev = level_in;
   end

   // History register
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         prev_ff <= IDLE_HIGH;
      end else begin
         prev_ff <= nxt_prev;
      end
   end

   // Edge is combinational so the counter steps on the same clock
   assign rise_out = level_in & ~prev_ff;

endmodule

// File: rtl/updown_counter.sv
`timescale 1ns/10ps
module updown_counter
   import updown_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Count inputs, idle high
   input wire logic count_up_in,
   input wire logic count_down_in,
   // Preset and control pins
   input wire logic [3:0] preset_data_in,
   input wire logic load_n_in,
   input wire logic async_zero_in,
   // Count outputs
   output logic count_bit0,
   output logic count_bit1,
   output logic count_bit2,
   output logic count_bit3,
   // Cascade outputs, active low
   output logic carry_out_n,
   output logic borrow_out_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   // Count state and cascade flags
   logic [3:0] count_ff;
   logic [3:0] nxt_count;
   logic carry_n_ff;
   logic nxt_carry_n;
   logic borrow_n_ff;
   logic nxt_borrow_n;

   // Software registers
   logic [2:0] ctrl_ff;
   logic [2:0] nxt_ctrl;
   logic [3:0] preset_ff;
   logic [3:0] nxt_preset;

   // Bus answer registers
   bus_phase_e phase_ff;
   bus_phase_e nxt_phase;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic pslverr_ff;
   logic nxt_pslverr;

   // Edges seen on the count pins
   logic up_rise;
   logic down_rise;

   // Decoded bus terms
   logic bus_commit;
   logic wr_commit;
   logic addr_hit;
   logic step_up;
   logic step_down;

   // Effective controls, pin or software
   logic clear_act;
   logic load_act;
   logic [3:0] load_val;
   logic inc_req;
   logic dec_req;

   // Edge detectors on each count input
   rise_detect up_edge (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .level_in(count_up_in),
      .rise_out(up_rise)
   );

   rise_detect down_edge (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .level_in(count_down_in),
      .rise_out(down_rise)
   );

   // Transfer completes on the edge where pready is seen high
   assign bus_commit = psel & penable & (phase_ff == BUS_DONE);
   assign wr_commit = bus_commit & pwrite;
   assign addr_hit = (paddr == CTRL_OFS) | (paddr == STEP_OFS) |
                     (paddr == STATUS_OFS) | (paddr == PRESET_OFS);
   assign step_up = wr_commit & (paddr == STEP_OFS) & pwdata[STEP_UP_BIT];
   assign step_down = wr_commit & (paddr == STEP_OFS) & pwdata[STEP_DOWN_BIT];

   // Merge pin and software control sources
   always_comb begin
      clear_act = async_zero_in | ctrl_ff[CTRL_CLEAR_BIT];
      load_act = ~load_n_in | ctrl_ff[CTRL_LOAD_BIT];
      // Pin or software load takes preset from its register when selected
      load_val = ctrl_ff[CTRL_SRC_BIT] ? preset_ff : preset_data_in;
      inc_req = up_rise | step_up;
      dec_req = down_rise | step_down;
   end

   // Next count: clear, then load, then one step
   always_comb begin
      nxt_count = count_ff;
      if (clear_act) begin
         nxt_count = CNT_ZERO;
      end else if (load_act) begin
         nxt_count = load_val;
      end else if (inc_req && !dec_req) begin
         // Whole word steps at once, no ripple
         nxt_count = count_ff + CNT_ONE;
      end else if (dec_req && !inc_req) begin
         nxt_count = count_ff - CNT_ONE;
      end else begin
         // Both edges together violate the idle-high rule; hold is safest
         nxt_count = count_ff;
      end
   end

   // Cascade flags from the new count and live count pins
   always_comb begin
      nxt_carry_n = ~((nxt_count == CNT_MAX) & ~count_up_in);
      nxt_borrow_n = ~((nxt_count == CNT_ZERO) & ~count_down_in);
   end

   // Count and flag registers
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         count_ff <= CNT_ZERO;
         carry_n_ff <= IDLE_HIGH;
         borrow_n_ff <= IDLE_HIGH;
      end else begin
         count_ff <= nxt_count;
         carry_n_ff <= nxt_carry_n;
         borrow_n_ff <= nxt_borrow_n;
      end
   end

   // Software register writes
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_preset = preset_ff;
      if (wr_commit && paddr == CTRL_OFS) begin
         nxt_ctrl = pwdata[2:0];
      end
      if (wr_commit && paddr == PRESET_OFS) begin
         nxt_preset = pwdata[3:0];
      end
   end

   // Bus phase and read data
   always_comb begin
      nxt_phase = phase_ff;
      nxt_prdata = prdata_ff;
      nxt_pslverr = pslverr_ff;
      case (phase_ff)
         BUS_WAIT: begin
            // Answer one cycle into the access phase
            if (psel && penable) begin
               nxt_phase = BUS_DONE;
               nxt_pslverr = ~addr_hit;
               nxt_prdata = '0;
               if (!pwrite) begin
                  if (paddr == CTRL_OFS) begin
                     nxt_prdata[2:0] = ctrl_ff;
                  end else if (paddr == STATUS_OFS) begin
                     nxt_prdata[STAT_CNT_LSB +: CNT_W] = count_ff;
                     nxt_prdata[STAT_CARRY_BIT] = carry_n_ff;
                     nxt_prdata[STAT_BORROW_BIT] = borrow_n_ff;
                     nxt_prdata[STAT_UP_BIT] = count_up_in;
                     nxt_prdata[STAT_DOWN_BIT] = count_down_in;
                  end else if (paddr == PRESET_OFS) begin
                     nxt_prdata[3:0] = preset_ff;
                  end else begin
                     // Step register and holes read zero
                     nxt_prdata = '0;
                  end
               end
            end
         end
         BUS_DONE: begin
            // Drop the answer after one cycle
            nxt_phase = BUS_WAIT;
            nxt_pslverr = 1'b0;
            nxt_prdata = '0;
         end
         default: begin
            nxt_phase = BUS_WAIT;
            nxt_pslverr = 1'b0;
            nxt_prdata = '0;
         end
      endcase
   end

   // Register and bus flops
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ctrl_ff <= CTRL_RST;
         preset_ff <= PRESET_RST;
         phase_ff <= BUS_WAIT;
         prdata_ff <= '0;
         pslverr_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         preset_ff <= nxt_preset;
         phase_ff <= nxt_phase;
         prdata_ff <= nxt_prdata;
         pslverr_ff <= nxt_pslverr;
      end
   end

   // Outputs straight from flops
   assign count_bit0 = count_ff[0];
   assign count_bit1 = count_ff[1];
   assign count_bit2 = count_ff[2];
   assign count_bit3 = count_ff[3];
   assign carry_out_n = carry_n_ff;
   assign borrow_out_n = borrow_n_ff;
   assign prdata = prdata_ff;
   assign pready = (phase_ff == BUS_DONE);
   assign pslverr = pslverr_ff;

endmodule

// File: sim/updown_counter_asserts.sv
`timescale 1ns/10ps
module updown_counter_asserts
   import updown_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Pins from the far side
   input wire logic count_up_in,
   input wire logic count_down_in,
   input wire logic [3:0] preset_data_in,
   input wire logic load_n_in,
   input wire logic async_zero_in,
   // Count and flags
   input wire logic count_bit0,
   input wire logic count_bit1,
   input wire logic count_bit2,
   input wire logic count_bit3,
   input wire logic carry_out_n,
   input wire logic borrow_out_n,
   // Bus handshake
   input wire logic psel,
   input wire logic penable,
   input wire logic pready
);
   logic [2:0] hist_ff; // Bus, down, up at last edge
   logic [2:0] nxt_hist;
   logic [3:0] cnt;
   logic quiet, up_r, dn_r;
   assign cnt = {count_bit3, count_bit2, count_bit1, count_bit0};
   assign up_r = count_up_in && !hist_ff[0];
   assign dn_r = count_down_in && !hist_ff[1];
   // Bus steps kept out of the pin checks
   assign quiet = load_n_in && !async_zero_in && !psel && !hist_ff[2];
   // Next history
   always_comb nxt_hist = {psel, count_down_in, count_up_in};
   // Reset high like the design, so no false edge
   always_ff @(posedge clk_sys) hist_ff <= sys_rst ? 3'b011 : nxt_hist;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   property p_carry; !$past(sys_rst) |-> carry_out_n == !(cnt == CNT_MAX && !$past(count_up_in)); endproperty
   a_carry: assert property (p_carry) else $error("carry flag");
   property p_borrow; !$past(sys_rst) |-> borrow_out_n == !(cnt == CNT_ZERO && !$past(count_down_in)); endproperty
   a_borrow: assert property (p_borrow) else $error("borrow flag");
   property p_up; up_r && !dn_r && quiet |=> cnt == $past(cnt) + CNT_ONE; endproperty
   a_up: assert property (p_up) else $error("up step");
   property p_down; dn_r && !up_r && quiet |=> cnt == $past(cnt) - CNT_ONE; endproperty
   a_down: assert property (p_down) else $error("down step");
   property p_hold; quiet && !up_r && !dn_r |=> $stable(cnt); endproperty
   a_hold: assert property (p_hold) else $error("count moved");
   property p_clear; async_zero_in |=> cnt == CNT_ZERO; endproperty
   a_clear: assert property (p_clear) else $error("clear");
   property p_load; !load_n_in && !async_zero_in |=> cnt == $past(preset_data_in); endproperty
   a_load: assert property (p_load) else $error("load");
   property p_wait; psel && penable && !pready |=> pready ##1 !pready; endproperty
   a_wait: assert property (p_wait) else $error("bus wait");
endmodule
bind updown_counter updown_counter_asserts chk (.*);

// File: sim/pin_driver.sv
`timescale 1ns/10ps
module pin_driver (
   // Clock in
   input wire logic clk_sys,
   // Pins to the counter
   output logic count_up_in,
   output logic count_down_in,
   output logic [3:0] preset_data_in,
   output logic load_n_in,
   output logic async_zero_in
);
   // Idle: both count inputs high, no load or clear
   initial begin
      {count_up_in, count_down_in} = 2'b11;
      {preset_data_in, load_n_in, async_zero_in} = 6'h02;
   end
   // Count pulse held low lo cycles; other input stays high
   task step(input logic up, input int lo);
      @(posedge clk_sys);
      if (up) count_up_in <= 1'b0;
      else count_down_in <= 1'b0;
      repeat (lo) @(posedge clk_sys);
      {count_up_in, count_down_in} <= 2'b11;
   endtask
   // Clear, load and preset levels, used for modulo starts
   task set_ctl(input logic z, input logic ld_n, input logic [3:0] v);
      @(posedge clk_sys);
      {async_zero_in, load_n_in, preset_data_in} <= {z, ld_n, v};
   endtask
endmodule

// File: sim/tb.sv
`timescale 1ns/10ps
module tb
   import updown_pkg::*;
;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic count_up_in, count_down_in, load_n_in, async_zero_in, pready, pslverr;
   logic count_bit0, count_bit1, count_bit2, count_bit3, carry_out_n, borrow_out_n;
   logic [3:0] preset_data_in, cnt;
   int fail_count = 0;
   int tests_run = 0;
   assign cnt = {count_bit3, count_bit2, count_bit1, count_bit0};
   always #12.5 clk_sys = ~clk_sys;
   pin_driver drv (.*);
   updown_counter uut (.*);
   // Compare and count
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Pass n edges, then sample settled outputs
   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // One APB transfer, held until pready is sampled
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task t_reset;
      chk("count", cnt, 4'h0);
      chk("flags", {carry_out_n, borrow_out_n}, 2'b11);
      apb(1'b0, STATUS_OFS, 32'h0000_0000);
      chk("status", rd, 32'h0000_00F0);
      apb(1'b1, 12'h010, 32'h0000_0007);
      chk("slverr", err, 1'b1);
      $display("t_reset done");
   endtask
   task t_up;
      drv.set_ctl(1'b0, 1'b0, 4'hE);
      drv.set_ctl(1'b0, 1'b1, 4'hE);
      cyc(2);
      chk("load", cnt, 4'hE);
      drv.step(1'b1, 1);
      cyc(2);
      chk("up", cnt, 4'hF);
      // Hold up low at fifteen: carry must go low to clock a next stage
      @(posedge clk_sys);
      drv.count_up_in <= 1'b0;
      cyc(2);
      chk("carry low", carry_out_n, 1'b0);
      @(posedge clk_sys);
      drv.count_up_in <= 1'b1;
      cyc(2);
      chk("wrap up", cnt, 4'h0);
      $display("t_up done");
   endtask
   task t_down;
      // Hold down low at zero: borrow must go low to clock a next stage
      @(posedge clk_sys);
      drv.count_down_in <= 1'b0;
      cyc(2);
      chk("borrow low", borrow_out_n, 1'b0);
      @(posedge clk_sys);
      drv.count_down_in <= 1'b1;
      cyc(2);
      chk("wrap down", cnt, 4'hF);
      drv.step(1'b0, 1);
      cyc(2);
      chk("down", cnt, 4'hE);
      $display("t_down done");
   endtask
   // Clear beats load and a count edge
   task t_clear;
      drv.set_ctl(1'b1, 1'b0, 4'h9);
      drv.step(1'b1, 1);
      cyc(2);
      chk("clear wins", cnt, 4'h0);
      drv.set_ctl(1'b0, 1'b1, 4'h9);
      cyc(2);
      chk("after clear", cnt, 4'h0);
      $display("t_clear done");
   endtask
   task t_bus;
      apb(1'b1, PRESET_OFS, 32'h0000_0005);
      apb(1'b0, PRESET_OFS, 32'h0000_0000);
      chk("preset", rd, 32'h0000_0005);
      apb(1'b1, STEP_OFS, 32'h0000_0001);
      cyc(3);
      chk("bus step", cnt, 4'h1);
      // Software load from the preset register, then release
      apb(1'b1, CTRL_OFS, 32'h0000_0006);
      apb(1'b1, CTRL_OFS, 32'h0000_0000);
      cyc(2);
      chk("soft load", cnt, 4'h5);
      $display("t_bus done");
   endtask
   task results;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      cyc(2);
      t_reset;
      t_up;
      t_down;
      t_clear;
      t_bus;
      results;
   end
   // Hang guard, far beyond the fewer than a hundred cycles used
   initial begin
      #(25 * 4000);
      fail_count++;
      results;
   end
endmodule
